// file: hsc_defines.svh
// Constants for the serial host-port command and settings block.
`ifndef HSC_DEFINES_SVH
`define HSC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define HSC_CLK_PERIOD_NS 20
`define HSC_T_MCLK_MIN_NS 160
`define HSC_T_MCLK_MAX_NS 165
`define HSC_T_SEL_LOW_NS 535
`define HSC_T_BIT_OUT_NS 400
`define HSC_T_BIT_OUT_CYC (`HSC_T_BIT_OUT_NS / `HSC_CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Command codes, low nibble of the command byte
// ----------------------------------------------------------------------------
`define HSC_CMD_LOAD_PRIMARY 4'h0
`define HSC_CMD_LOAD_SECONDARY 4'h1
`define HSC_CMD_LOAD_THRESHOLD 4'h2
`define HSC_CMD_LOAD_DUTY 4'h3
`define HSC_CMD_LOAD_BYTE_COUNT 4'h5
`define HSC_CMD_LOAD_RANDOM_COUNT 4'h6
`define HSC_CMD_READ_AUX 4'h8
`define HSC_CMD_READ_SYSTEM_INFO 4'h9
`define HSC_CMD_WRITE_AUX 4'hA
`define HSC_CMD_WRITE_SYSTEM_INFO 4'hB
`define HSC_CMD_RANDOM_READ_DATA 4'hC
`define HSC_CMD_RANDOM_READ_FLAG 4'hD
`define HSC_CMD_RANDOM_WRITE_DATA 4'hE
`define HSC_CMD_RANDOM_WRITE_FLAG 4'hF

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define HSC_QUARTER_MSB 5
`define HSC_QUARTER_LSB 4
`define HSC_THRESHOLD_MSB 3
`define HSC_RANDOM_COUNT_MSB 6
`define HSC_PRIMARY_MSB 6
`define HSC_PRIMARY_RESET 7'h00
`define HSC_SECONDARY_RESET 8'h0C
`define HSC_BYTE_RESET 8'h00
`define HSC_DUTY_HALF 8'h80

`endif

// file: hsc_pkg.sv
// Types shared by the serial host-port command and settings block.
package hsc_pkg;

  // --------------------------------------------------------------------------
  // Transfer types and operating modes
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    HSC_DATA_WRITE = 2'b00,
    HSC_DATA_READ = 2'b01,
    HSC_COMMAND_WRITE = 2'b10,
    HSC_STATUS_READ = 2'b11
  } hsc_xfer_t;

  typedef enum logic [1:0] {
    HSC_MODE_PLAY = 2'b00,
    HSC_MODE_INVALID = 2'b01,
    HSC_MODE_AFTER_RECORD = 2'b10,
    HSC_MODE_RECORD = 2'b11
  } hsc_mode_t;

  // --------------------------------------------------------------------------
  // Register layouts and carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic extFreqRegulationEnable;
    logic freqRegulationEnable;
    logic labelRecordEnable;
    logic resyncDisable;
    logic speedOverride;
    hsc_mode_t operatingMode;
  } hsc_settings0_t;

  typedef struct packed {
    logic pinOut3;
    logic pinOut2;
    logic testHighBit;
    logic correctedWriteDisable;
    logic portableTracking;
    logic audioBusMasterEnable;
    logic pinOut1;
    logic secondaryTestBit;
  } hsc_settings1_t;

  typedef logic [3:0][7:0] hsc_status_t;

  typedef struct packed {
    logic valid;
    logic [3:0] op;
    logic [1:0] quarter;
    logic [7:0] data;
  } hsc_xfer_req_t;

  typedef struct packed {
    logic useHostDuty;
    logic resyncSuppress;
    logic labelWrite;
    logic freqRegActive;
    logic extFreqRegActive;
    logic audioBusMaster;
    logic portableTracking;
    logic correctedWriteDisable;
  } hsc_control_t;

endpackage

// file: hsc_host_port.sv
// Serial host port: link capture, command decode and settings registers.
`timescale 1ns/10ps
`include "hsc_defines.svh"

module hsc_host_port
  import hsc_pkg::*;
(
  input logic clk_sys,
  input logic rst,
  input logic hostBitClock,
  input logic hostSelect,
  input logic transferTypeLow,
  input logic transferTypeHigh,
  input logic hostSerialDataIn,
  output logic hostSerialDataOut,
  output logic hostSerialDataOe,
  input hsc_status_t statusIn,
  input logic [7:0] readDataIn,
  input logic [7:0] computedDuty,
  output logic readRequest,
  output hsc_xfer_req_t writeRequest,
  output logic [7:0] commandSelect,
  output hsc_settings0_t settingsPrimary,
  output hsc_settings1_t settingsSecondary,
  output logic [3:0] auxFlagThreshold,
  output logic [7:0] speedDutyValue,
  output logic [7:0] byteCounterReg,
  output logic [6:0] randomAccessCounterReg,
  output logic [7:0] capstanDuty,
  output hsc_control_t control
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  localparam int SY_SEL = 6;
  localparam int SY_TYPE_HIGH = 5;
  localparam int SY_TYPE_LOW = 4;
  localparam int SY_DONE = 3;
  localparam int SY_LATCH = 2;
  localparam int SY_TXBIT = 1;
  localparam int SY_STARTED = 0;
  localparam int OUT_DELAY_MAX = `HSC_T_BIT_OUT_CYC;

  // Link-domain state.
  logic linkRst;
  logic [2:0] bitCount;
  logic [7:0] rxShift;
  logic [7:0] rxByte;
  logic [7:0] txShift;
  logic txBit;
  logic linkStarted;
  logic doneToggle;
  logic latchToggle;

  // System-domain state.
  logic [6:0] asyncIn;
  logic [6:0] syncA;
  logic [6:0] syncB;
  logic selPrev;
  logic donePrev;
  logic latchPrev;
  logic selNow;
  logic selRise;
  logic doneEvent;
  logic latchEvent;
  logic txBitSync;
  logic startedSync;
  hsc_xfer_t typeNow;
  hsc_xfer_t xferType;
  logic [7:0] txWord;
  logic [1:0] statusPtr;
  logic isRead;
  logic [3:0] cmdOp;
  hsc_mode_t mode;

  // --------------------------------------------------------------------------
  // Link domain, clocked by the host bit clock
  // --------------------------------------------------------------------------

  // Host select low holds the bit counter in reset, so a partial byte from a
  // select period that ended off a byte boundary never leaks into the next.
  assign linkRst = rst | ~hostSelect;

  // Bit counter and receive shifter; the bit clock may stop between frames,
  // which is harmless because select low resets everything here.
  always_ff @(posedge hostBitClock or posedge linkRst)
  begin
    if (linkRst)
    begin
      bitCount <= 3'h0;
      rxShift <= 8'h00;
      linkStarted <= 1'b0;
    end
    else
    begin
      bitCount <= bitCount + 3'h1;
      rxShift <= {rxShift[6:0], hostSerialDataIn};
      linkStarted <= 1'b1;
    end
  end

  // Completed bytes are held and announced by a toggle. The toggle is reset
  // only by the system reset: clearing it with select would fake an event.
  always_ff @(posedge hostBitClock or posedge rst)
  begin
    if (rst)
    begin
      rxByte <= 8'h00;
      doneToggle <= 1'b0;
    end
    else if (bitCount == 3'h7)
    begin
      rxByte <= {rxShift[6:0], hostSerialDataIn};
      doneToggle <= ~doneToggle;
    end
  end

  // Transmit side. Bits 6:0 are taken from txWord at the first edge of each
  // byte and bit 7 at the last edge of the byte before; txWord is held steady
  // by the system side for seven bit periods around those edges, so reading it here is a safe word crossing.
  always_ff @(posedge hostBitClock or posedge rst)
  begin
    if (rst)
    begin
      txShift <= 8'h00;
      txBit <= 1'b0;
      latchToggle <= 1'b0;
    end
    else if (bitCount == 3'h0)
    begin
      txShift <= {txWord[5:0], 2'b00};
      txBit <= txWord[6];
      latchToggle <= ~latchToggle;
    end
    else if (bitCount == 3'h7)
    begin
      txBit <= txWord[7];
    end
    else
    begin
      txShift <= {txShift[6:0], 1'b0};
      txBit <= txShift[7];
    end
  end

  // a_bit_reset: before the first bit edge of a frame the counter is clear.
  a_bit_reset: assert property (@(posedge hostBitClock) disable iff (linkRst)
    !linkStarted |-> bitCount == 3'h0)
    else $error("Bit counter not cleared at frame start.");

  // --------------------------------------------------------------------------
  // Crossing into the system clock
  // --------------------------------------------------------------------------

  // Select, both type pins and the four link-domain flags pass two flops before use.
  assign asyncIn = {hostSelect, transferTypeHigh, transferTypeLow, doneToggle,
                    latchToggle, txBit, linkStarted};

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      syncA <= 7'h00;
      syncB <= 7'h00;
    end
    else
    begin
      syncA <= asyncIn;
      syncB <= syncA;
    end
  end

  // Edge detectors look only at the second synchroniser stage.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      selPrev <= 1'b0;
      donePrev <= 1'b0;
      latchPrev <= 1'b0;
    end
    else
    begin
      selPrev <= syncB[SY_SEL];
      donePrev <= syncB[SY_DONE];
      latchPrev <= syncB[SY_LATCH];
    end
  end

  assign selNow = syncB[SY_SEL];
  assign selRise = selNow & ~selPrev;
  assign doneEvent = syncB[SY_DONE] ^ donePrev;
  assign latchEvent = syncB[SY_LATCH] ^ latchPrev;
  assign txBitSync = syncB[SY_TXBIT];
  assign startedSync = syncB[SY_STARTED];
  assign typeNow = hsc_xfer_t'({syncB[SY_TYPE_HIGH], syncB[SY_TYPE_LOW]});
  assign isRead = (xferType == HSC_DATA_READ) || (xferType == HSC_STATUS_READ);
  assign cmdOp = commandSelect[3:0];
  assign mode = settingsPrimary.operatingMode;

  // --------------------------------------------------------------------------
  // Transfer type and read data supply
  // --------------------------------------------------------------------------

  // The type is frozen at the select rise. Reads run one byte ahead: a new
  // byte is fetched as soon as the link has taken the previous one, so one
  // extra byte is consumed when a read frame ends.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      xferType <= HSC_DATA_WRITE;
      txWord <= 8'h00;
      statusPtr <= 2'h0;
      readRequest <= 1'b0;
    end
    else
    begin
      readRequest <= 1'b0;
      if (selRise)
      begin
        xferType <= typeNow;
        if (typeNow == HSC_STATUS_READ)
        begin
          txWord <= statusIn[0];
          statusPtr <= 2'h1;
        end
        else if (typeNow == HSC_DATA_READ)
        begin
          txWord <= readDataIn;
          readRequest <= 1'b1;
        end
      end
      else if (latchEvent && selNow)
      begin
        if (xferType == HSC_STATUS_READ)
        begin
          txWord <= statusIn[statusPtr];
          statusPtr <= statusPtr + 2'h1;
        end
        else if (xferType == HSC_DATA_READ)
        begin
          txWord <= readDataIn;
          readRequest <= 1'b1;
        end
      end
    end
  end

  // a_type_latch: the transfer type follows the lines sampled at select rise.
  a_type_latch: assert property (@(posedge clk_sys) disable iff (rst)
    selRise |=> xferType == $past(typeNow))
    else $error("Transfer type not latched at select rise.");

  // --------------------------------------------------------------------------
  // Serial data pin
  // --------------------------------------------------------------------------

  // Before the first bit edge the pin shows the top bit of the first byte;
  // after it, the link's next bit. The enable waits for a settled select.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      hostSerialDataOut <= 1'b0;
      hostSerialDataOe <= 1'b0;
    end
    else
    begin
      hostSerialDataOut <= startedSync ? txBitSync : txWord[7];
      hostSerialDataOe <= selNow && selPrev && isRead;
    end
  end

  // a_bit_delay: a new link bit reaches the pin within the output delay.
  a_bit_delay: assert property (@(posedge clk_sys) disable iff (rst)
    (startedSync && selNow && $changed(txBitSync)) |->
      ##[1:OUT_DELAY_MAX] (hostSerialDataOut == txBitSync))
    else $error("Read bit not driven in time.");

  // --------------------------------------------------------------------------
  // Command register and indirect write targets
  // --------------------------------------------------------------------------

  // A command byte selects the target of all following data transfers until
  // the next command byte arrives. Writes that do not match the command are
  // dropped; keeping the two compatible is the host's task.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      commandSelect <= `HSC_BYTE_RESET;
      settingsPrimary <= `HSC_PRIMARY_RESET;
      settingsSecondary <= `HSC_SECONDARY_RESET;
      auxFlagThreshold <= 4'h0;
      speedDutyValue <= `HSC_BYTE_RESET;
      byteCounterReg <= `HSC_BYTE_RESET;
      randomAccessCounterReg <= 7'h00;
      writeRequest <= '0;
    end
    else
    begin
      writeRequest.valid <= 1'b0;
      if (doneEvent && xferType == HSC_COMMAND_WRITE)
      begin
        commandSelect <= rxByte;
      end
      else if (doneEvent && xferType == HSC_DATA_WRITE)
      begin
        if (cmdOp == `HSC_CMD_LOAD_PRIMARY)
        begin
          settingsPrimary <= rxByte[`HSC_PRIMARY_MSB:0];
        end
        else if (cmdOp == `HSC_CMD_LOAD_SECONDARY)
        begin
          settingsSecondary <= rxByte;
        end
        else if (cmdOp == `HSC_CMD_LOAD_THRESHOLD)
        begin
          auxFlagThreshold <= rxByte[`HSC_THRESHOLD_MSB:0];
        end
        else if (cmdOp == `HSC_CMD_LOAD_DUTY)
        begin
          speedDutyValue <= rxByte;
        end
        else if (cmdOp == `HSC_CMD_LOAD_BYTE_COUNT)
        begin
          byteCounterReg <= rxByte;
        end
        else if (cmdOp == `HSC_CMD_LOAD_RANDOM_COUNT)
        begin
          randomAccessCounterReg <= rxByte[`HSC_RANDOM_COUNT_MSB:0];
        end
        else if (cmdOp == `HSC_CMD_WRITE_AUX || cmdOp == `HSC_CMD_WRITE_SYSTEM_INFO ||
                 cmdOp == `HSC_CMD_RANDOM_WRITE_DATA ||
                 cmdOp == `HSC_CMD_RANDOM_WRITE_FLAG)
        begin
          writeRequest.valid <= 1'b1;
          writeRequest.op <= cmdOp;
          writeRequest.quarter <= commandSelect[`HSC_QUARTER_MSB:`HSC_QUARTER_LSB];
          writeRequest.data <= rxByte;
        end
      end
    end
  end

  // a_cmd_persist: the command changes only on a command write.
  a_cmd_persist: assert property (@(posedge clk_sys) disable iff (rst)
    !(doneEvent && xferType == HSC_COMMAND_WRITE) |=> $stable(commandSelect))
    else $error("Command changed without a command write.");

  // a_primary_load: a data write after the primary load command lands there.
  a_primary_load: assert property (@(posedge clk_sys) disable iff (rst)
    (doneEvent && xferType == HSC_DATA_WRITE && cmdOp == `HSC_CMD_LOAD_PRIMARY)
      |=> settingsPrimary == $past(rxByte[`HSC_PRIMARY_MSB:0]))
    else $error("Primary settings not loaded.");

  // a_duty_load: the duty register takes the byte and only on its command.
  a_duty_load: assert property (@(posedge clk_sys) disable iff (rst)
    ((doneEvent && xferType == HSC_DATA_WRITE && cmdOp == `HSC_CMD_LOAD_DUTY)
      |=> speedDutyValue == $past(rxByte)) and
    ((cmdOp != `HSC_CMD_LOAD_DUTY) |=> $stable(speedDutyValue)))
    else $error("Speed duty register load wrong.");

  // a_ram_quarter: random and info writes carry the command's quarter bits.
  a_ram_quarter: assert property (@(posedge clk_sys) disable iff (rst)
    writeRequest.valid |->
      writeRequest.quarter == commandSelect[`HSC_QUARTER_MSB:`HSC_QUARTER_LSB] &&
      writeRequest.op[3])
    else $error("Write request quarter or op wrong.");

  // --------------------------------------------------------------------------
  // Settings decode toward the rest of the device
  // --------------------------------------------------------------------------

  // Mode-dependent gating of the settings. Record mode always forces the
  // audio bus to slave and, without the override, a fixed half duty.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      control <= '0;
      capstanDuty <= `HSC_DUTY_HALF;
    end
    else
    begin
      control.useHostDuty <= settingsPrimary.speedOverride;
      control.resyncSuppress <= settingsPrimary.resyncDisable;
      control.labelWrite <= settingsPrimary.labelRecordEnable &&
        (mode == HSC_MODE_RECORD || mode == HSC_MODE_AFTER_RECORD);
      control.freqRegActive <= settingsPrimary.freqRegulationEnable &&
        (mode == HSC_MODE_PLAY || mode == HSC_MODE_AFTER_RECORD);
      control.extFreqRegActive <= settingsPrimary.extFreqRegulationEnable &&
        settingsPrimary.freqRegulationEnable &&
        (mode == HSC_MODE_PLAY || mode == HSC_MODE_AFTER_RECORD);
      control.audioBusMaster <= settingsSecondary.audioBusMasterEnable &&
        (mode == HSC_MODE_PLAY || mode == HSC_MODE_AFTER_RECORD);
      control.portableTracking <= settingsSecondary.portableTracking;
      control.correctedWriteDisable <= settingsSecondary.correctedWriteDisable;
      if (settingsPrimary.speedOverride)
      begin
        capstanDuty <= speedDutyValue;
      end
      else if (mode == HSC_MODE_RECORD)
      begin
        capstanDuty <= `HSC_DUTY_HALF;
      end
      else
      begin
        capstanDuty <= computedDuty;
      end
    end
  end

  // a_host_duty: with the override set the output duty follows the register,
  // one cycle late, even while the host rewrites the duty value.
  a_host_duty: assert property (@(posedge clk_sys) disable iff (rst)
    (settingsPrimary.speedOverride && $stable(settingsPrimary) ##1
      settingsPrimary.speedOverride) |=> capstanDuty == $past(speedDutyValue))
    else $error("Capstan duty ignores host override.");

  // a_record_slave: record mode never yields audio bus mastership.
  a_record_slave: assert property (@(posedge clk_sys) disable iff (rst)
    (mode == HSC_MODE_RECORD) |=> !control.audioBusMaster)
    else $error("Audio bus master in record mode.");

  // a_ext_gate: extended regulation never active without plain regulation.
  a_ext_gate: assert property (@(posedge clk_sys) disable iff (rst)
    control.extFreqRegActive |-> control.freqRegActive)
    else $error("Extended regulation without frequency regulation.");

  // a_label_mode: labels are never written in play mode.
  a_label_mode: assert property (@(posedge clk_sys) disable iff (rst)
    (mode == HSC_MODE_PLAY) |=> !control.labelWrite)
    else $error("Label write outside recording modes.");

endmodule

// file: hsc_host_model.sv
// Host-side model of the serial link: framing, bit clock and data line.
`timescale 1ns/10ps
module hsc_host_model (
  output logic hostBitClock,
  output logic hostSelect,
  output logic transferTypeLow,
  output logic transferTypeHigh,
  output logic hostSerialDataIn,
  input wire logic hostSerialDataOut,
  input wire logic hostSerialDataOe
);
  logic [7:0] txb [4];
  logic [7:0] rxb [4];

  // The link idles with select and bit clock low; the clock only runs in frames.
  initial
  begin
    hostBitClock = 1'b0;
    hostSelect = 1'b0;
    {transferTypeHigh, transferTypeLow} = 2'b00;
    hostSerialDataIn = 1'b0;
  end

  // One frame, bits MSB first, with a 64 ns bit clock. A read bit is taken
  // 18 ns after the rising edge: the device needs two system clocks or more
  // to answer that edge, so the bit shown before it still stands.
  task automatic frame(input logic [1:0] typ, input int nbits);
    int i;
    {transferTypeHigh, transferTypeLow} = typ;
    #240 hostSelect = 1'b1;
    #560;
    for (i = 0; i < nbits; i++)
    begin
      hostSerialDataIn = typ[0] ? ~hostSerialDataIn : txb[i / 8][7 - i % 8];
      #24 hostBitClock = 1'b1;
      // An undriven line reads as the inverse, so a missing enable shows up.
      #18 if (typ[0]) rxb[i / 8][7 - i % 8] = hostSerialDataOe ? hostSerialDataOut :
        ~hostSerialDataOut;
      #14 hostBitClock = 1'b0;
      #8;
    end
    #240 hostSelect = 1'b0;
    // A released line must not keep showing the last bit.
    hostSerialDataIn = ~hostSerialDataIn;
    #560;
  endtask
endmodule

// file: hsc_host_port_tb_top.sv
// Self-checking testbench for the serial host-port command block.
`timescale 1ns/10ps
module hsc_host_port_tb_top
  import hsc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic hbc, hsel, ttl, tth, hdi, hdo, hoe, readRequest;
  hsc_status_t statusIn = '0;
  logic [7:0] readDataIn = 8'h00;
  logic [7:0] computedDuty = 8'h00;
  hsc_xfer_req_t writeRequest, lastReq;
  logic [7:0] commandSelect, speedDutyValue, byteCounterReg, capstanDuty, got, d, c, s;
  hsc_settings0_t settingsPrimary;
  hsc_settings1_t settingsSecondary;
  logic [3:0] auxFlagThreshold;
  logic [6:0] randomAccessCounterReg;
  hsc_control_t control;
  int err_count = 0;
  int comparisons = 0;
  int seed = 83;
  int reqCount = 0;
  int rdCount = 0;
  int i, k, dutyExp;
  logic [3:0] codes [6] = '{4'h2, 4'h3, 4'h5, 4'h6, 4'h4, 4'h7};
  logic [3:0] wcodes [4] = '{4'hA, 4'hB, 4'hE, 4'hF};

  always #10 clk_sys = ~clk_sys;

  hsc_host_model hsc_host_model_i (.hostBitClock(hbc), .hostSelect(hsel),
    .transferTypeLow(ttl), .transferTypeHigh(tth), .hostSerialDataIn(hdi),
    .hostSerialDataOut(hdo), .hostSerialDataOe(hoe));

  hsc_host_port hsc_host_port_i (.clk_sys(clk_sys), .rst(rst), .hostBitClock(hbc),
    .hostSelect(hsel), .transferTypeLow(ttl), .transferTypeHigh(tth),
    .hostSerialDataIn(hdi), .hostSerialDataOut(hdo), .hostSerialDataOe(hoe),
    .statusIn(statusIn), .readDataIn(readDataIn), .computedDuty(computedDuty),
    .readRequest(readRequest), .writeRequest(writeRequest), .commandSelect(commandSelect),
    .settingsPrimary(settingsPrimary), .settingsSecondary(settingsSecondary),
    .auxFlagThreshold(auxFlagThreshold), .speedDutyValue(speedDutyValue),
    .byteCounterReg(byteCounterReg), .randomAccessCounterReg(randomAccessCounterReg),
    .capstanDuty(capstanDuty), .control(control));

  // Counts write pulses; a pulse longer than one cycle shows as extra counts.
  always @(posedge clk_sys)
  begin
    if (writeRequest.valid === 1'b1)
    begin
      lastReq <= writeRequest;
      reqCount <= reqCount + 1;
    end
    if (readRequest === 1'b1)
    begin
      rdCount <= rdCount + 1;
    end
  end

  task chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Sends one whole-byte frame of the given type, then lets the result settle.
  task send(input logic [1:0] typ, input logic [7:0] b);
    hsc_host_model_i.txb[0] = b;
    hsc_host_model_i.frame(typ, 8);
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  // Control outputs as the settings and operating mode should give them.
  function automatic logic [7:0] ctlExp(input logic [6:0] p, input logic [7:0] q);
    logic pa, ar;
    pa = (p[1:0] == 2'b00);
    ar = (p[1:0] == 2'b10);
    return {p[2], p[3], p[4] & (ar | p[1:0] == 2'b11), p[5] & (pa | ar),
      p[6] & p[5] & (pa | ar), q[2] & (pa | ar), q[3], q[4]};
  endfunction

  task results();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #1900000;
    err_count++;
    $display("[ERR] %0t run did not complete", $time);
    results();
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    computedDuty = $random(seed);
    repeat (4) @(negedge clk_sys);
    chk({1'b0, settingsPrimary}, 8'h00);
    chk(settingsSecondary, 8'h0C);
    chk(capstanDuty, computedDuty);
    $display("test reset done");
    // Indirect loads: second write must win, unmapped nibbles issue no write request.
    for (i = 0; i < 6; i++)
    begin
      c = $random(seed);
      c[3:0] = codes[i];
      d = $random(seed);
      k = reqCount;
      send(2'b10, c);
      send(2'b00, ~d);
      send(2'b00, d);
      chk(commandSelect, c);
      case (i)
        0: chk({4'h0, auxFlagThreshold}, {4'h0, d[3:0]});
        1: chk(speedDutyValue, d);
        2: chk(byteCounterReg, d);
        3: chk({1'b0, randomAccessCounterReg}, {1'b0, d[6:0]});
        default: chk(8'(reqCount - k), 8'h00);
      endcase
      if (i == 1) dutyExp = d;
    end
    $display("test loads done");
    // Random settings pairs, checking every derived control and duty source.
    for (i = 0; i < 8; i++)
    begin
      s = $random(seed) & 32'hDE;
      d = $random(seed);
      send(2'b10, 8'h01);
      send(2'b00, s);
      send(2'b10, 8'hF0);
      send(2'b00, d);
      chk(settingsSecondary, s);
      chk({1'b0, settingsPrimary}, {1'b0, d[6:0]});
      chk(control, ctlExp(d[6:0], s));
      got = d[2] ? 8'(dutyExp) : (d[1:0] == 2'b11 ? 8'h80 : computedDuty);
      chk(capstanDuty, got);
    end
    $display("test settings done");
    // Write commands must issue exactly one request with op and data; random writes also check quarter.
    for (i = 0; i < 4; i++)
    begin
      c = $random(seed);
      c[3:0] = wcodes[i];
      d = $random(seed);
      k = reqCount;
      send(2'b10, c);
      send(2'b00, d);
      chk(8'(reqCount - k), 8'h01);
      chk({lastReq.op, i > 1 ? lastReq.quarter : c[5:4], 2'b00}, {c[3:0], c[5:4], 2'b00});
      chk(lastReq.data, d);
    end
    $display("test writes done");
    // Status frame of four bytes, then a short one that must restart at byte 0.
    @(negedge clk_sys);
    statusIn = $random(seed);
    hsc_host_model_i.frame(2'b11, 32);
    for (i = 0; i < 4; i++)
      chk(hsc_host_model_i.rxb[i], statusIn[i]);
    hsc_host_model_i.frame(2'b11, 8);
    chk(hsc_host_model_i.rxb[0], statusIn[0]);
    // Aux read, then random read: each returns the byte offered and, with
    // the one-byte prefetch, takes two bytes per one-byte frame.
    for (i = 0; i < 2; i++)
    begin
      send(2'b10, i ? 8'h2D : 8'h08);
      readDataIn = $random(seed);
      k = rdCount;
      hsc_host_model_i.frame(2'b01, 8);
      chk(hsc_host_model_i.rxb[0], readDataIn);
      chk(8'(rdCount - k), 8'h02);
    end
    $display("test reads done");
    // A partial byte must be dropped when select falls.
    hsc_host_model_i.txb[0] = 8'hFF;
    hsc_host_model_i.frame(2'b10, 3);
    send(2'b10, 8'h25);
    chk(commandSelect, 8'h25);
    $display("test partial done");
    results();
  end
endmodule
